// file: src/sat_map.vh
// register indices, field positions, reset values and counts of the aux-bit register bank
`ifndef SAT_MAP_VH
`define SAT_MAP_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define SAT_IDX_PWR_CTRL      16'hf051
`define SAT_IDX_RX_READY      16'hf60f
`define SAT_IDX_RX_UD_RIGHT   16'hf640
`define SAT_IDX_RX_VB_LEFT    16'hf650
`define SAT_IDX_RX_VB_RIGHT   16'hf660
`define SAT_IDX_RX_PB_LEFT    16'hf670
`define SAT_IDX_RX_PB_RIGHT   16'hf680
`define SAT_IDX_TX_EN         16'hf690
`define SAT_IDX_TX_CTRL       16'hf691
`define SAT_IDX_TX_AUX_SRC    16'hf69f
`define SAT_IDX_TX_CS_LEFT    16'hf6a0

// ****************************************************************
// store groups: 12 words of 16 bits carry 192 frames
// ****************************************************************
`define SAT_GRP_WORDS         4'hc
`define SAT_LAST_WORD         4'hb
`define SAT_BLOCK_FRAMES      8'hc0
`define SAT_LAST_FRAME        8'hbf
`define SAT_RX_LANES          5
`define SAT_GRP_TX_CS         3'h5
`define SAT_GRP_NONE          3'h7

// ****************************************************************
// field positions and codes
// ****************************************************************
`define SAT_TX_EN_BIT         0
`define SAT_AUX_SRC_BIT       0
`define SAT_READY_BIT         0
`define SAT_PWR_TX_BIT        2
`define SAT_LEN_LSB           0
`define SAT_LEN_24            2'h0
`define SAT_LEN_20            2'h1
`define SAT_LEN_16            2'h2
`define SAT_LEN_AUTO          2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define SAT_RST_WORD          16'h0000
`define SAT_RST_PWR_CTRL      16'h0004

`endif

// file: src/sat_mem.v
// word store with registered read data and clear on reset
`timescale 1ns/1ps
module sat_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 72,
    parameter AW = 7
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire we_i,
    input wire [AW-1:0] addr_i,
    input wire [WIDTH-1:0] wdata_i,
    output reg [WIDTH-1:0] rdata_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    integer i;

    // read-first: a write and a read of one word return the old value
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
            rdata_o <= {WIDTH{1'b0}};
        end else begin
            rdata_o <= mem_q[addr_i];
            if (we_i) begin
                mem_q[addr_i] <= wdata_i;
            end
        end
    end
endmodule // sat_mem

// file: src/sat_regs.v
// register bank for receiver aux-bit stores and transmitter control
//
// Contract
// (RULE1) right user bits held in 12 words
// (RULE2) validity bits per channel, left then right
// (RULE3) parity bits per channel, left then right
// (RULE4) receive stores read-only, zero after reset
// (RULE5) disabled transmitter keeps sending zero audio
// (RULE6) enable bit 0, reset 0
// (RULE7) only power-gate bit powers transmitter down
// (RULE8) max 24 bits, drop surplus low bits
// (RULE9) length codes 00=24, 01=20, 10=16
// (RULE10) code 11 takes length from receiver
// (RULE11) aux source: 0 registers, 1 receiver
// (RULE12) register mode takes aux bits from stores
// (RULE13) software fills left status words, source 0
// (RULE14) ready flag rises after all 192 frames
// (RULE15) word bit order follows ascending frame order
`timescale 1ns/1ps
`include "sat_map.vh"
module sat_regs #(
    parameter AUDIO_W = 24,
    parameter MEM_DEPTH = 72
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [17:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire rx_block_start_i,
    input wire rx_frame_i,
    input wire rx_user_right_i,
    input wire rx_valid_left_i,
    input wire rx_valid_right_i,
    input wire rx_parity_left_i,
    input wire rx_parity_right_i,
    input wire rx_cs_left_i,
    input wire [1:0] rx_cs_len_i,
    input wire tx_audio_load_i,
    input wire [AUDIO_W-1:0] tx_audio_i,
    output reg [AUDIO_W-1:0] tx_audio_o,
    input wire tx_cs_req_i,
    input wire [7:0] tx_frame_idx_i,
    output reg tx_cs_bit_o,
    output reg tx_cs_ack_o,
    output wire tx_output_on_o,
    output wire tx_aux_from_rx_o,
    output wire transmitter_power_gate_o,
    output wire rx_block_complete_flag_o
);
    localparam LANES = `SAT_RX_LANES;
    localparam SEQ_IDLE = 3'h0;
    localparam SEQ_LAST = 3'h5;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function [2:0] grp_of;
        input [15:0] idx;
        begin
            case (idx[15:4])
                `SAT_IDX_RX_UD_RIGHT >> 4: grp_of = 3'h0;
                `SAT_IDX_RX_VB_LEFT >> 4: grp_of = 3'h1;
                `SAT_IDX_RX_VB_RIGHT >> 4: grp_of = 3'h2;
                `SAT_IDX_RX_PB_LEFT >> 4: grp_of = 3'h3;
                `SAT_IDX_RX_PB_RIGHT >> 4: grp_of = 3'h4;
                `SAT_IDX_TX_CS_LEFT >> 4: grp_of = `SAT_GRP_TX_CS;
                default: grp_of = `SAT_GRP_NONE;
            endcase
            if (idx[3:0] >= `SAT_GRP_WORDS) begin
                grp_of = `SAT_GRP_NONE;
            end
        end
    endfunction

    // store address = group * 12 + word
    function [6:0] mem_addr;
        input [2:0] grp;
        input [3:0] word;
        begin
            mem_addr = {1'b0, grp, 3'b000} + {2'b00, grp, 2'b00} + {3'b000, word};
        end
    endfunction

    function [AUDIO_W-1:0] len_mask;
        input [1:0] code;
        begin
            case (code)
                `SAT_LEN_20: len_mask = {{(AUDIO_W-4){1'b1}}, 4'h0};
                `SAT_LEN_16: len_mask = {{(AUDIO_W-8){1'b1}}, 8'h00};
                default: len_mask = {AUDIO_W{1'b1}};
            endcase
        end
    endfunction

    // ****************************************************************
    // control registers
    // ****************************************************************
    reg tx_en_q;
    reg [1:0] len_sel_q;
    reg aux_src_q;
    reg [15:0] pwr_ctrl_q;
    reg ready_q;
    reg rd_wait_q;
    reg [2:0] seq_cnt_q;
    reg tx_pend_q;
    reg tx_rd_q;
    reg [7:0] tx_idx_q;
    reg [7:0] frame_cnt_q;
    reg [3:0] hold_word_q;
    reg [LANES*16-1:0] acc_q;
    reg [LANES*16-1:0] hold_q;
    wire [15:0] mem_rdata;
    wire [15:0] bus_idx = paddr_i[17:2];
    wire [2:0] bus_grp = grp_of(bus_idx);
    wire access = psel_i & penable_i;
    wire mem_hit = (bus_grp != `SAT_GRP_NONE);
    wire seq_busy = (seq_cnt_q != SEQ_IDLE);
    wire tx_go = tx_pend_q & ~seq_busy;
    wire apb_mem_go = access & mem_hit & ~rd_wait_q & ~seq_busy & ~tx_pend_q;
    reg reg_hit;
    reg [15:0] reg_val;

    always @* begin
        reg_hit = 1'b1;
        reg_val = `SAT_RST_WORD;
        case (bus_idx)
            `SAT_IDX_TX_EN: reg_val[`SAT_TX_EN_BIT] = tx_en_q;
            `SAT_IDX_TX_CTRL: reg_val[`SAT_LEN_LSB +: 2] = len_sel_q;
            `SAT_IDX_TX_AUX_SRC: reg_val[`SAT_AUX_SRC_BIT] = aux_src_q;
            `SAT_IDX_PWR_CTRL: reg_val = pwr_ctrl_q;
            `SAT_IDX_RX_READY: reg_val[`SAT_READY_BIT] = ready_q;
            default: reg_hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // apb answer
    // ****************************************************************
    // store reads answer one cycle later because the read data is registered
    assign pready_o = access & (~mem_hit | rd_wait_q | (apb_mem_go & pwrite_i));
    assign pslverr_o = pready_o & ~mem_hit & ~reg_hit;
    assign prdata_o = rd_wait_q ? {16'h0000, mem_rdata} : {16'h0000, reg_val};

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_en_q <= 1'b0;
            len_sel_q <= `SAT_LEN_24;
            aux_src_q <= 1'b0;
            pwr_ctrl_q <= `SAT_RST_PWR_CTRL;
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= apb_mem_go & ~pwrite_i;
            if (access & pwrite_i & ~mem_hit) begin
                case (bus_idx)
                    `SAT_IDX_TX_EN: tx_en_q <= pwdata_i[`SAT_TX_EN_BIT]; // RULE6
                    `SAT_IDX_TX_CTRL: len_sel_q <= pwdata_i[`SAT_LEN_LSB +: 2]; // RULE9
                    `SAT_IDX_TX_AUX_SRC: aux_src_q <= pwdata_i[`SAT_AUX_SRC_BIT]; // RULE11
                    `SAT_IDX_PWR_CTRL: pwr_ctrl_q <= pwdata_i[15:0];
                    default: pwr_ctrl_q <= pwr_ctrl_q;
                endcase
            end
        end
    end

    // ****************************************************************
    // transmitter control outputs
    // ****************************************************************
    assign tx_output_on_o = tx_en_q;
    // enable does not gate power; only the power bit does
    assign transmitter_power_gate_o = pwr_ctrl_q[`SAT_PWR_TX_BIT]; // RULE7
    assign tx_aux_from_rx_o = aux_src_q; // RULE11

    wire [1:0] eff_len = (len_sel_q == `SAT_LEN_AUTO) ? rx_cs_len_i : len_sel_q; // RULE10
    wire [AUDIO_W-1:0] audio_mask = len_mask(eff_len); // RULE8 RULE9

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_audio_o <= {AUDIO_W{1'b0}};
        end else if (~tx_en_q) begin
            tx_audio_o <= {AUDIO_W{1'b0}}; // RULE5
        end else if (tx_audio_load_i) begin
            tx_audio_o <= tx_audio_i & audio_mask; // RULE8
        end
    end

    // ****************************************************************
    // receive collection
    // ****************************************************************
    wire [LANES-1:0] rx_bits = {rx_parity_right_i, rx_parity_left_i, rx_valid_right_i,
                                rx_valid_left_i, rx_user_right_i};
    wire [7:0] cur_frame = rx_block_start_i ? 8'h00 : frame_cnt_q;
    wire frame_take = rx_frame_i & (cur_frame < `SAT_BLOCK_FRAMES);
    wire word_done = frame_take & (cur_frame[3:0] == 4'hf);

    genvar l;
    generate
        for (l = 0; l < LANES; l = l + 1) begin : g_lane
            wire [15:0] acc_now = acc_q[l*16 +: 16];
            reg [15:0] acc_d;
            always @* begin
                acc_d = acc_now;
                acc_d[cur_frame[3:0]] = rx_bits[l]; // RULE15
            end
            always @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    acc_q[l*16 +: 16] <= `SAT_RST_WORD;
                    hold_q[l*16 +: 16] <= `SAT_RST_WORD;
                end else if (frame_take) begin
                    acc_q[l*16 +: 16] <= acc_d;
                    if (word_done) begin
                        hold_q[l*16 +: 16] <= acc_d;
                    end
                end
            end
        end
    endgenerate

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_cnt_q <= 8'h00;
            hold_word_q <= 4'h0;
            seq_cnt_q <= SEQ_IDLE;
            ready_q <= 1'b0;
        end else begin
            if (frame_take) begin
                frame_cnt_q <= cur_frame + 8'h01;
            end else if (rx_block_start_i) begin
                frame_cnt_q <= 8'h00;
            end
            if (word_done) begin
                hold_word_q <= cur_frame[7:4];
                seq_cnt_q <= 3'h1;
            end else if (seq_cnt_q == SEQ_LAST) begin
                seq_cnt_q <= SEQ_IDLE;
            end else if (seq_busy) begin
                seq_cnt_q <= seq_cnt_q + 3'h1;
            end
            // set wins over the clear of a new block
            if (seq_cnt_q == SEQ_LAST && hold_word_q == `SAT_LAST_WORD) begin
                ready_q <= 1'b1; // RULE14
            end else if (rx_block_start_i) begin
                ready_q <= 1'b0;
            end
        end
    end
    assign rx_block_complete_flag_o = ready_q;

    // ****************************************************************
    // store port: sequencer, then transmitter lookup, then bus
    // ****************************************************************
    reg mem_we;
    reg [6:0] mem_addr_sel;
    reg [15:0] mem_wdata;
    wire [2:0] seq_lane = seq_cnt_q - 3'h1;

    always @* begin
        mem_we = 1'b0;
        mem_addr_sel = 7'h00;
        mem_wdata = `SAT_RST_WORD;
        if (seq_busy) begin
            mem_we = 1'b1; // RULE1 RULE2 RULE3
            mem_addr_sel = mem_addr(seq_lane, hold_word_q);
            mem_wdata = hold_q[seq_lane*16 +: 16];
        end else if (tx_go) begin
            mem_addr_sel = mem_addr(`SAT_GRP_TX_CS, tx_idx_q[7:4]); // RULE12
        end else if (apb_mem_go) begin
            mem_addr_sel = mem_addr(bus_grp, bus_idx[3:0]);
            // receive groups ignore bus writes
            mem_we = pwrite_i & (bus_grp == `SAT_GRP_TX_CS); // RULE4 RULE13
            mem_wdata = pwdata_i[15:0];
        end
    end

    sat_mem #(
        .WIDTH(16),
        .DEPTH(MEM_DEPTH),
        .AW(7)
    ) u_store (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .addr_i(mem_addr_sel),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    ); // RULE4

    // ****************************************************************
    // transmitter status-bit lookup
    // ****************************************************************
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_pend_q <= 1'b0;
            tx_rd_q <= 1'b0;
            tx_idx_q <= 8'h00;
            tx_cs_bit_o <= 1'b0;
            tx_cs_ack_o <= 1'b0;
        end else begin
            tx_rd_q <= tx_go;
            tx_cs_ack_o <= tx_rd_q;
            if (tx_cs_req_i) begin
                tx_pend_q <= 1'b1;
                tx_idx_q <= tx_frame_idx_i;
            end else if (tx_go) begin
                tx_pend_q <= 1'b0;
            end
            // receiver copy bypasses the store data, though the lookup still waits for and takes its store read slot
            if (tx_rd_q) begin
                tx_cs_bit_o <= aux_src_q ? rx_cs_left_i : mem_rdata[tx_idx_q[3:0]]; // RULE11 RULE12
            end
        end
    end
endmodule // sat_regs

// file: testbench/sat_regs_asserts.sv
// port-level checks for the aux-bit register bank
`timescale 1ns/1ps
module sat_regs_asserts #(
    parameter AUDIO_W = 24
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [17:0] paddr_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire rx_block_start_i,
    input wire rx_frame_i,
    input wire tx_audio_load_i,
    input wire [AUDIO_W-1:0] tx_audio_i,
    input wire [AUDIO_W-1:0] tx_audio_o,
    input wire tx_cs_req_i,
    input wire tx_cs_bit_o,
    input wire tx_cs_ack_o,
    input wire tx_output_on_o,
    input wire transmitter_power_gate_o,
    input wire rx_block_complete_flag_o
);
    // power control write taken this cycle
    wire pwr_wr = psel_i & penable_i & pwrite_i & pready_o & (paddr_i[17:2] == 16'hf051);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    chk_err_needs_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
        else $error("error flag outside access");
    chk_gap_word_err: assert property (pready_o && paddr_i[5:4] == 2'h3 &&
        paddr_i[17:6] inside {12'hf64, 12'hf65, 12'hf66, 12'hf67, 12'hf68, 12'hf6a}
        |-> pslverr_o && prdata_o == 32'h00000000) else $error("gap word not refused");
    chk_enable_fast: assert property (psel_i && penable_i && paddr_i[17:2] == 16'hf690
        |-> pready_o && prdata_o[31:1] == 31'h0) else $error("enable access slow or wide");
    chk_audio_zeroed: assert property (!tx_output_on_o |=> tx_audio_o == {AUDIO_W{1'b0}})
        else $error("audio not zero while disabled");
    chk_audio_top_kept: assert property (tx_output_on_o && tx_audio_load_i |=>
        tx_audio_o[AUDIO_W-1:AUDIO_W-16] == $past(tx_audio_i[AUDIO_W-1:AUDIO_W-16]))
        else $error("audio high bits lost");
    chk_flag_after_frame: assert property ($rose(rx_block_complete_flag_o) |->
        $past(rx_frame_i, 6) || $past(rx_frame_i, 7)) else $error("flag rose without frame");
    chk_flag_holds: assert property (rx_block_complete_flag_o && !rx_block_start_i
        |=> rx_block_complete_flag_o) else $error("flag dropped early");
    chk_flag_cleared: assert property ($fell(rx_block_complete_flag_o) |->
        $past(rx_block_start_i)) else $error("flag fell without block start");
    chk_lookup_answer: assert property (tx_cs_req_i |-> ##[3:8] tx_cs_ack_o)
        else $error("status lookup not answered");
    chk_bit_with_ack: assert property ($changed(tx_cs_bit_o) |-> tx_cs_ack_o)
        else $error("status bit moved without ack");
    chk_gate_by_write: assert property ($changed(transmitter_power_gate_o) |->
        $past(pwr_wr)) else $error("power gate moved without write");
endmodule // sat_regs_asserts

// file: testbench/sat_rx_src.sv
// stand-in receiver: one block of 192 decoded frames per go pulse
`timescale 1ns/1ps
module sat_rx_src #(
    parameter GAP = 7
) (
    input wire core_clk_i,
    input wire go_i,
    output logic rx_block_start_o,
    output logic rx_frame_o,
    output logic [4:0] lanes_o
);
    int n;
    initial begin
        rx_block_start_o = 1'b0;
        rx_frame_o = 1'b0;
        lanes_o = 5'h1f;
        forever begin
            @(posedge core_clk_i);
            if (go_i) begin
                for (n = 0; n < 192; n++) begin
                    rx_block_start_o <= (n == 0);
                    rx_frame_o <= 1'b1;
                    lanes_o <= n[4:0];
                    @(posedge core_clk_i);
                    rx_block_start_o <= 1'b0;
                    rx_frame_o <= 1'b0;
                    // no data between frames, so never leave the last bits up
                    lanes_o <= ~n[4:0];
                    repeat (GAP) @(posedge core_clk_i);
                end
            end
        end
    end
endmodule // sat_rx_src

// file: testbench/sat_regs_bench.sv
// self-checking bench for the aux-bit register bank
`timescale 1ns/1ps
module sat_regs_bench;
    logic core_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [17:0] paddr_i = 18'h00000;
    logic [31:0] pwdata_i = 32'h00000000, rd;
    logic go = 1'b0, rx_cs_left_i = 1'b0, tx_audio_load_i = 1'b0, tx_cs_req_i = 1'b0, er;
    logic [1:0] rx_cs_len_i = 2'h1;
    logic [23:0] tx_audio_i = 24'h000000;
    logic [7:0] tx_frame_idx_i = 8'h00;
    wire [31:0] prdata_o;
    wire [23:0] tx_audio_o;
    wire [4:0] lane;
    wire pready_o, pslverr_o, rx_block_start_i, rx_frame_i, tx_cs_bit_o, tx_cs_ack_o;
    wire tx_output_on_o, tx_aux_from_rx_o, transmitter_power_gate_o, rx_block_complete_flag_o;
    int fail_count = 0, check_count = 0, i, w, g;
    logic [15:0] zero_idx [7] = '{16'hf690, 16'hf691, 16'hf69f, 16'hf6a0, 16'hf6ab, 16'hf640, 16'hf68b};
    logic [15:0] bad_idx [4] = '{16'hf64c, 16'hf68f, 16'hf6ac, 16'hf692};
    logic [23:0] keep [4] = '{24'hffffff, 24'hfffff0, 24'hffff00, 24'hfffff0};
    logic [7:0] fr [6] = '{8'h00, 8'h01, 8'h02, 8'hb0, 8'hbe, 8'hbf};
    logic [5:0] cs_exp = 6'b101101;
    always #5 core_clk_i = ~core_clk_i;
    sat_rx_src src (.core_clk_i, .go_i(go), .rx_block_start_o(rx_block_start_i),
        .rx_frame_o(rx_frame_i), .lanes_o(lane));
    sat_regs dut (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .rx_block_start_i, .rx_frame_i,
        .rx_user_right_i(lane[0]), .rx_valid_left_i(lane[1]), .rx_valid_right_i(lane[2]),
        .rx_parity_left_i(lane[3]), .rx_parity_right_i(lane[4]), .rx_cs_left_i, .rx_cs_len_i,
        .tx_audio_load_i, .tx_audio_i, .tx_audio_o, .tx_cs_req_i, .tx_frame_idx_i, .tx_cs_bit_o,
        .tx_cs_ack_o, .tx_output_on_o, .tx_aux_from_rx_o, .transmitter_power_gate_o,
        .rx_block_complete_flag_o);
    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pready is combinational: its settled value at the falling edge is what the next edge takes
    task apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'h0};
        pwdata_i <= {16'h0000, wd};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        n = 0;
        @(negedge core_clk_i);
        while (pready_o !== 1'b1 && n < 40) begin
            @(negedge core_clk_i);
            n++;
        end
        // a slave that never answers is a failure, not a silent pass
        if (n >= 40) fail_count++;
        rd = prdata_o;
        er = pslverr_o;
        @(posedge core_clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task rdc(input logic [15:0] idx, input logic [31:0] exp, input logic ee);
        apb(1'b0, idx, 16'h0000);
        cmp(rd, exp);
        cmp({31'h0, er}, {31'h0, ee});
    endtask
    task aud(input logic [23:0] v, input logic [23:0] exp);
        tx_audio_load_i <= 1'b1;
        tx_audio_i <= v;
        @(posedge core_clk_i);
        tx_audio_load_i <= 1'b0;
        @(negedge core_clk_i);
        cmp({8'h00, tx_audio_o}, {8'h00, exp});
        @(posedge core_clk_i);
    endtask
    task look(input logic [7:0] f, input logic exp);
        int n;
        tx_cs_req_i <= 1'b1;
        tx_frame_idx_i <= f;
        @(posedge core_clk_i);
        tx_cs_req_i <= 1'b0;
        n = 0;
        @(negedge core_clk_i);
        while (tx_cs_ack_o !== 1'b1 && n < 20) begin
            @(negedge core_clk_i);
            n++;
        end
        cmp({30'h0, tx_cs_ack_o, tx_cs_bit_o}, {30'h0, 1'b1, exp});
        @(posedge core_clk_i);
    endtask
    function automatic logic [15:0] pat(input int ln, input int wd);
        logic [15:0] v;
        for (int b = 0; b < 16; b++) v[b] = ((16 * wd + b) >> ln) & 1;
        return v;
    endfunction
    task final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        cmp({30'h0, transmitter_power_gate_o, tx_output_on_o}, 32'h2);
        foreach (zero_idx[i]) rdc(zero_idx[i], 32'h0, 1'b0);
        rdc(16'hf051, 32'h4, 1'b0);
        foreach (bad_idx[i]) rdc(bad_idx[i], 32'h0, 1'b1);
        apb(1'b1, 16'hf690, 16'h0001);
        cmp({31'h0, tx_output_on_o}, 32'h1);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 16'hf691, i[15:0]);
            aud(24'habcdef, 24'habcdef & keep[i]);
        end
        rx_cs_len_i <= 2'h2;
        aud(24'h123456, 24'h123400);
        rdc(16'hf691, 32'h3, 1'b0);
        apb(1'b1, 16'hf690, 16'h0000);
        aud(24'h654321, 24'h000000);
        cmp({31'h0, transmitter_power_gate_o}, 32'h1);
        apb(1'b1, 16'hf051, 16'h0000);
        cmp({31'h0, transmitter_power_gate_o}, 32'h0);
        apb(1'b1, 16'hf051, 16'h0004);
        // one full block; the flag must not come before the last frame
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        i = 0;
        while (rx_block_complete_flag_o !== 1'b1 && i < 3000) begin
            @(negedge core_clk_i);
            i++;
        end
        @(posedge core_clk_i);
        cmp({31'h0, i >= 1520 && i < 3000}, 32'h1);
        rdc(16'hf60f, 32'h1, 1'b0);
        for (g = 0; g < 5; g++) for (w = 0; w < 12; w++)
            rdc({12'hf64 + g[11:0], w[3:0]}, {16'h0, pat(g, w)}, 1'b0);
        apb(1'b1, 16'hf645, 16'h1234);
        rdc(16'hf645, {16'h0, pat(0, 5)}, 1'b0);
        apb(1'b1, 16'hf6a0, 16'h0005);
        apb(1'b1, 16'hf6ab, 16'h8001);
        rdc(16'hf6a0, 32'h5, 1'b0);
        foreach (fr[i]) look(fr[i], cs_exp[i]);
        apb(1'b1, 16'hf69f, 16'h0001);
        cmp({31'h0, tx_aux_from_rx_o}, 32'h1);
        rx_cs_left_i <= 1'b1;
        look(8'h01, 1'b1);
        rx_cs_left_i <= 1'b0;
        look(8'h00, 1'b0);
        apb(1'b1, 16'hf69f, 16'h0000);
        look(8'h00, 1'b1);
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        repeat (4) @(negedge core_clk_i);
        cmp({31'h0, rx_block_complete_flag_o}, 32'h0);
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rdc(16'hf66b, 32'h0, 1'b0);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        final_report();
    end
endmodule // sat_regs_bench
bind sat_regs sat_regs_asserts #(.AUDIO_W(AUDIO_W)) u_chk (.core_clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .rx_block_start_i,
    .rx_frame_i, .tx_audio_load_i, .tx_audio_i, .tx_audio_o, .tx_cs_req_i, .tx_cs_bit_o,
    .tx_cs_ack_o, .tx_output_on_o, .transmitter_power_gate_o, .rx_block_complete_flag_o);
